/* rtl/totalize_period_pkg.sv */
`default_nettype none
package totalize_period_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT_LO = 8'h08;
  localparam logic [7:0] OFS_COUNT_HI = 8'h0C;
  localparam logic [7:0] OFS_MAX_LO = 8'h10;
  localparam logic [7:0] OFS_MAX_HI = 8'h14;
  localparam logic [7:0] OFS_MIN_LO = 8'h18;
  localparam logic [7:0] OFS_MIN_HI = 8'h1C;
  localparam logic [7:0] OFS_CMP0_LO = 8'h20;
  localparam logic [7:0] OFS_CMP0_HI = 8'h24;
  localparam logic [7:0] OFS_CMP1_LO = 8'h28;
  localparam logic [7:0] OFS_CMP1_HI = 8'h2C;
  localparam logic [7:0] OFS_PERIOD_LO = 8'h30;
  localparam logic [7:0] OFS_PERIOD_HI = 8'h34;

  // values after reset
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [63:0] MAX_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: tick base is a 96 mhz rate made from the 250 mhz clock
  localparam int CLOCK_MHZ = 250;
  localparam int BASE_MHZ = 96;
  localparam logic [7:0] PHASE_INC = 8'(BASE_MHZ);
  localparam logic [7:0] PHASE_MOD = 8'(CLOCK_MHZ);
  localparam int TICK0_PS = 20830;
  localparam int TICK1_PS = 208300;
  localparam int TICK2_PS = 2083300;
  localparam int TICK3_PS = 20833300;
  localparam logic [11:0] TICK0_DIV = 12'((TICK0_PS * BASE_MHZ + 500000) / 1000000);
  localparam logic [11:0] TICK1_DIV = 12'((TICK1_PS * BASE_MHZ + 500000) / 1000000);
  localparam logic [11:0] TICK2_DIV = 12'((TICK2_PS * BASE_MHZ + 500000) / 1000000);
  localparam logic [11:0] TICK3_DIV = 12'((TICK3_PS * BASE_MHZ + 500000) / 1000000);

  // periods per latched result
  localparam logic [9:0] AVG_ONE = 10'h001;
  localparam logic [9:0] AVG_TEN = 10'h00A;
  localparam logic [9:0] AVG_HUNDRED = 10'h064;
  localparam logic [9:0] AVG_THOUSAND = 10'h3E8;

  typedef enum logic [2:0] {
    GATE_NONE = 3'h0,
    GATE_DIRECTION = 3'h1,
    GATE_GATING = 3'h2,
    GATE_CLEAR_RELOAD = 3'h3,
    GATE_TRIGGER = 3'h4
  } gate_mode_type;

  typedef enum logic [1:0] {
    period_average_one = 2'h0,
    period_average_ten = 2'h1,
    period_average_hundred = 2'h2,
    period_average_thousand = 2'h3
  } average_type;

  // trigger state, gray along wait -> run
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01
  } trig_state_type;

  // control register layout, msb first
  typedef struct packed {
    logic [14:0] unused;
    logic period_gate;
    logic [1:0] tick_size;
    average_type average;
    logic period_falling;
    logic [2:0] gate_mode;
    logic unused2;
    logic output_init_high;
    logic output_on;
    logic count_down;
    logic non_recycle;
    logic range_limit;
    logic clear_on_read;
    logic period_mode;
  } control_type;

endpackage : totalize_period_pkg
`default_nettype wire

/* rtl/totalize_period_counter.sv */
`default_nettype none
module totalize_period_counter (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic COUNT_INPUT_PIN,
  input wire logic COUNT_GATE_PIN,
  output logic COUNT_OUTPUT_PIN,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import totalize_period_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_PERIOD_HI;
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [1:0] in_sync;
  logic [1:0] gate_sync;
  logic in_prev;
  logic gate_prev;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      in_sync <= 2'h0;
      gate_sync <= 2'h0;
      in_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      in_sync <= {in_sync[0], COUNT_INPUT_PIN};
      gate_sync <= {gate_sync[0], COUNT_GATE_PIN};
      in_prev <= in_sync[1];
      gate_prev <= gate_sync[1];
    end
  end
  logic in_level;
  logic gate_level;
  logic in_rise;
  logic in_fall;
  logic gate_rise;
  assign in_level = in_sync[1];
  assign gate_level = gate_sync[1];
  assign in_rise = in_level && !in_prev;
  assign in_fall = !in_level && in_prev;
  assign gate_rise = gate_level && !gate_prev;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and register file
  control_type control;
  logic [63:0] max_limit;
  logic [63:0] min_limit;
  logic [63:0] cmp0;
  logic [63:0] cmp1;
  logic [31:0] load_lo;
  logic [31:0] snap_hi;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [63:0] count;
  logic [63:0] period_result;
  logic stopped;
  logic out_level;
  logic period_valid;
  trig_state_type trig_state;

  control_type next_control;
  logic [63:0] next_max_limit;
  logic [63:0] next_min_limit;
  logic [63:0] next_cmp0;
  logic [63:0] next_cmp1;
  logic [31:0] next_load_lo;
  logic [31:0] next_snap_hi;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic do_read;
  logic load_count;
  logic read_count;
  logic [63:0] load_value;

  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign ARREADY = !RVALID;

  always_comb begin
    next_control = control;
    next_max_limit = max_limit;
    next_min_limit = min_limit;
    next_cmp0 = cmp0;
    next_cmp1 = cmp1;
    next_load_lo = load_lo;
    next_snap_hi = snap_hi;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = BVALID;
    next_bresp = BRESP;
    next_rvalid = RVALID;
    next_rdata = RDATA;
    next_rresp = RRESP;
    load_count = 1'b0;
    read_count = 1'b0;
    load_value = {w_data, load_lo};
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    do_write = aw_held && w_held && !BVALID;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (aw_addr)
        OFS_CONTROL: begin
          next_control = control_type'(merge(control, w_data, w_strb));
          next_control.unused = 15'h0000;
          next_control.unused2 = 1'b0;
        end
        OFS_COUNT_LO: next_load_lo = merge(load_lo, w_data, w_strb);
        OFS_COUNT_HI: begin
          load_count = 1'b1;
          load_value = {merge(count[63:32], w_data, w_strb), load_lo};
        end
        OFS_MAX_LO: next_max_limit[31:0] = merge(max_limit[31:0], w_data, w_strb);
        OFS_MAX_HI: next_max_limit[63:32] = merge(max_limit[63:32], w_data, w_strb);
        OFS_MIN_LO: next_min_limit[31:0] = merge(min_limit[31:0], w_data, w_strb);
        OFS_MIN_HI: next_min_limit[63:32] = merge(min_limit[63:32], w_data, w_strb);
        OFS_CMP0_LO: next_cmp0[31:0] = merge(cmp0[31:0], w_data, w_strb);
        OFS_CMP0_HI: next_cmp0[63:32] = merge(cmp0[63:32], w_data, w_strb);
        OFS_CMP1_LO: next_cmp1[31:0] = merge(cmp1[31:0], w_data, w_strb);
        OFS_CMP1_HI: next_cmp1[63:32] = merge(cmp1[63:32], w_data, w_strb);
        default: begin
        end
      endcase
    end
    if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
    end
    do_read = ARVALID && ARREADY;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      case (ARADDR)
        OFS_CONTROL: next_rdata = control;
        OFS_STATUS: next_rdata = {28'h000_0000, period_valid, trig_state == ST_RUN,
                                  stopped, out_level};
        OFS_COUNT_LO: begin
          next_rdata = count[31:0];
          next_snap_hi = count[63:32];
          read_count = !control.period_mode;
        end
        OFS_PERIOD_LO: begin
          next_rdata = period_result[31:0];
          next_snap_hi = period_result[63:32];
        end
        OFS_COUNT_HI: next_rdata = snap_hi;
        OFS_PERIOD_HI: next_rdata = snap_hi;
        OFS_MAX_LO: next_rdata = max_limit[31:0];
        OFS_MAX_HI: next_rdata = max_limit[63:32];
        OFS_MIN_LO: next_rdata = min_limit[31:0];
        OFS_MIN_HI: next_rdata = min_limit[63:32];
        OFS_CMP0_LO: next_rdata = cmp0[31:0];
        OFS_CMP0_HI: next_rdata = cmp0[63:32];
        OFS_CMP1_LO: next_rdata = cmp1[31:0];
        OFS_CMP1_HI: next_rdata = cmp1[63:32];
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      control <= control_type'(CONTROL_RESET);
      max_limit <= MAX_RESET;
      min_limit <= ZERO64;
      cmp0 <= ZERO64;
      cmp1 <= ZERO64;
      load_lo <= 32'h0000_0000;
      snap_hi <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else begin
      control <= next_control;
      max_limit <= next_max_limit;
      min_limit <= next_min_limit;
      cmp0 <= next_cmp0;
      cmp1 <= next_cmp1;
      load_lo <= next_load_lo;
      snap_hi <= next_snap_hi;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      BVALID <= next_bvalid;
      BRESP <= next_bresp;
      RVALID <= next_rvalid;
      RDATA <= next_rdata;
      RRESP <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // totalize counter
  logic [63:0] next_count;
  logic next_out_level;
  trig_state_type next_trig_state;
  logic count_up;
  logic limited;
  logic at_limit;
  logic step;
  logic [63:0] clear_value;
  logic control_written;

  assign control_written = do_write && aw_addr == OFS_CONTROL;
  assign limited = control.range_limit || control.non_recycle;
  assign clear_value = control.range_limit ? min_limit : ZERO64;

  always_comb begin
    next_count = count;
    next_trig_state = trig_state;
    next_out_level = out_level;
    if (control.gate_mode == GATE_DIRECTION) begin
      count_up = gate_level;
    end else begin
      count_up = !control.count_down;
    end
    at_limit = limited && (count_up ? count == max_limit : count == min_limit);
    step = in_rise && trig_state == ST_RUN;
    if (control.gate_mode == GATE_GATING && !gate_level) begin
      step = 1'b0;
    end
    case (trig_state)
      ST_WAIT: begin
        if (control.gate_mode != GATE_TRIGGER || gate_rise) begin
          next_trig_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (control_written && next_control.gate_mode == GATE_TRIGGER) begin
          next_trig_state = ST_WAIT;
        end
      end
      default: next_trig_state = ST_WAIT;
    endcase
    if (control.period_mode) begin
      next_count = count;
    end else if (load_count) begin
      next_count = load_value;
    end else if (read_count && control.clear_on_read) begin
      next_count = clear_value;
    end else if (control.gate_mode == GATE_CLEAR_RELOAD && gate_rise) begin
      next_count = clear_value;
    end else if (step) begin
      if (at_limit && control.non_recycle) begin
        next_count = count;
      end else if (at_limit) begin
        next_count = count_up ? min_limit : max_limit;
      end else if (count_up) begin
        next_count = count + 64'h0000_0000_0000_0001;
      end else begin
        next_count = count - 64'h0000_0000_0000_0001;
      end
    end
    if (!control.output_on) begin
      next_out_level = control.output_init_high;
    end else if (count == cmp0) begin
      next_out_level = !control.output_init_high;
    end else if (count == cmp1) begin
      next_out_level = control.output_init_high;
    end
  end

  assign stopped = control.non_recycle && at_limit;
  assign COUNT_OUTPUT_PIN = out_level;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count <= ZERO64;
      out_level <= 1'b0;
      trig_state <= ST_WAIT;
    end else begin
      count <= next_count;
      out_level <= next_out_level;
      trig_state <= next_trig_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period measurement
  logic [7:0] phase;
  logic [11:0] base_count;
  logic [63:0] tick_total;
  logic [9:0] edges;
  logic started;
  logic [7:0] next_phase;
  logic [11:0] next_base_count;
  logic [63:0] next_tick_total;
  logic [9:0] next_edges;
  logic next_started;
  logic [63:0] next_period_result;
  logic next_period_valid;
  logic base_pulse;
  logic tick;
  logic like_edge;
  logic period_run;
  logic [11:0] tick_div;
  logic [9:0] avg_count;
  logic [8:0] phase_sum;

  always_comb begin
    next_phase = phase;
    next_base_count = base_count;
    next_tick_total = tick_total;
    next_edges = edges;
    next_started = started;
    next_period_result = period_result;
    next_period_valid = period_valid;
    case (control.tick_size)
      2'h0: tick_div = TICK0_DIV;
      2'h1: tick_div = TICK1_DIV;
      2'h2: tick_div = TICK2_DIV;
      default: tick_div = TICK3_DIV;
    endcase
    case (control.average)
      period_average_one: avg_count = AVG_ONE;
      period_average_ten: avg_count = AVG_TEN;
      period_average_hundred: avg_count = AVG_HUNDRED;
      default: avg_count = AVG_THOUSAND;
    endcase
    phase_sum = {1'b0, phase} + {1'b0, PHASE_INC};
    base_pulse = phase_sum >= {1'b0, PHASE_MOD};
    next_phase = base_pulse ? 8'(phase_sum - {1'b0, PHASE_MOD}) : phase_sum[7:0];
    like_edge = control.period_falling ? in_fall : in_rise;
    period_run = !control.period_gate || gate_level;
    tick = 1'b0;
    if (started && period_run && base_pulse) begin
      if (base_count + 12'h001 >= tick_div) begin
        next_base_count = 12'h000;
        tick = 1'b1;
      end else begin
        next_base_count = base_count + 12'h001;
      end
    end
    if (tick) begin
      next_tick_total = tick_total + 64'h0000_0000_0000_0001;
    end
    if (!control.period_mode || control_written) begin
      next_started = 1'b0;
      next_edges = 10'h000;
    end else if (like_edge) begin
      next_started = 1'b1;
      if (!started) begin
        next_base_count = 12'h000;
        next_tick_total = ZERO64;
        next_edges = 10'h000;
      end else if (edges + 10'h001 >= avg_count) begin
        next_period_result = tick_total;
        next_period_valid = 1'b1;
        next_edges = 10'h000;
        next_base_count = 12'h000;
        next_tick_total = ZERO64;
      end else begin
        next_edges = edges + 10'h001;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase <= 8'h00;
      base_count <= 12'h000;
      tick_total <= ZERO64;
      edges <= 10'h000;
      started <= 1'b0;
      period_result <= ZERO64;
      period_valid <= 1'b0;
    end else begin
      phase <= next_phase;
      base_count <= next_base_count;
      tick_total <= next_tick_total;
      edges <= next_edges;
      started <= next_started;
      period_result <= next_period_result;
      period_valid <= next_period_valid;
    end
  end

endmodule : totalize_period_counter
`default_nettype wire

/* dv/pulse_source.sv */
`default_nettype none
module pulse_source (
  input wire logic clk,
  input wire logic [15:0] half,
  input wire logic [15:0] count,
  input wire logic go,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  initial busy = 1'b0;
  // count of zero runs a square wave until go drops
  always @(posedge go) begin
    busy <= 1'b1;
    for (int i = 0; i < 2 * count || (count == 0 && go); i++) begin
      repeat (half) @(posedge clk);
      pin <= !pin;
    end
    busy <= 1'b0;
  end
endmodule : pulse_source
`default_nettype wire

/* dv/totalize_period_counter_assertions.sv */
`default_nettype none
module totalize_period_counter_assertions
  import totalize_period_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic COUNT_OUTPUT_PIN,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic [1:0] age;
  logic [1:0] next_age;
  always_comb begin
    next_age = age;
    if (age != 2'h3) next_age = age + 2'h1;
  end
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) age <= 2'h0;
    else age <= next_age;
  end
  chk_out_init_low: assert property (age != 2'h3 |-> !COUNT_OUTPUT_PIN)
    else $error("output pin not low after reset");
  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data not held");
  chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write answer late");
  chk_write_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response not held");
  chk_ar_block: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while answer pending");
  chk_aw_block: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  chk_bad_read: assert property (ARVALID && ARREADY && ARADDR > OFS_PERIOD_HI |=>
    RRESP == RESP_SLVERR && RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  cover property (RVALID && !RREADY);
  cover property (BVALID && BREADY);
  cover property ($rose(COUNT_OUTPUT_PIN));
endmodule : totalize_period_counter_assertions
bind totalize_period_counter totalize_period_counter_assertions i_chk (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .COUNT_OUTPUT_PIN(COUNT_OUTPUT_PIN), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
`default_nettype wire

/* dv/test_totalize_period_counter.sv */
`default_nettype none
module test_totalize_period_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import totalize_period_pkg::*;
  localparam logic [63:0] LB = 64'h0000_0001_0000_0000;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic gate = 1'b0, go = 1'b0, slow = 1'b0, pin, busy, cout;
  logic [15:0] half = 16'h0004, cnt = 16'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [63:0] cv;
  int miscompares = 0;
  int compares = 0;
  always #2 CLOCK = ~CLOCK;
  totalize_period_counter i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .COUNT_INPUT_PIN(pin),
    .COUNT_GATE_PIN(gate), .COUNT_OUTPUT_PIN(cout), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  pulse_source i_src (.clk(CLOCK), .half(half), .count(cnt), .go(go), .pin(pin),
    .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    do begin
      @(posedge CLOCK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do begin
      @(posedge CLOCK);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rdat = rdata;
    resp = rresp;
  endtask : rd
  task automatic ld(input logic [63:0] v);
    wr(OFS_COUNT_LO, v[31:0]);
    wr(OFS_COUNT_HI, v[63:32]);
  endtask : ld
  task automatic cnt_is(input logic [63:0] exp);
    rd(OFS_COUNT_LO);
    cv[31:0] = rdat;
    rd(OFS_COUNT_HI);
    cv[63:32] = rdat;
    check(cv, exp);
  endtask : cnt_is
  task automatic pulses(input int n);
    @(posedge CLOCK);
    half <= 16'h0004;
    cnt <= 16'(n);
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    wait (!busy);
    repeat (8) @(posedge CLOCK);
  endtask : pulses
  task automatic gate_to(input logic v);
    @(posedge CLOCK);
    gate <= v;
    repeat (6) @(posedge CLOCK);
  endtask : gate_to
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    slow = 1'b1;
    rd(OFS_CONTROL);
    check(rdat, CONTROL_RESET);
    rd(OFS_MAX_HI);
    check(rdat, MAX_RESET[63:32]);
    rd(8'h40);
    check(resp, RESP_SLVERR);
    wr(8'h41, 32'h0000_0001);
    check(resp, RESP_SLVERR);
    slow = 1'b0;
    check(cout, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_direction;
    pulses(5);
    cnt_is(64'h5);
    wr(OFS_CONTROL, 32'h0000_0010);
    pulses(3);
    cnt_is(64'h2);
    wr(OFS_CONTROL, 32'h0000_0110);
    gate_to(1'b1);
    pulses(4);
    cnt_is(64'h6);
    gate_to(1'b0);
    pulses(1);
    cnt_is(64'h5);
    wr(OFS_CONTROL, 32'h0000_0002);
    ld(64'h0);
    pulses(4);
    cnt_is(64'h4);
    cnt_is(64'h0);
    $display("test direction done");
  endtask : t_direction
  task automatic t_limits;
    wr(OFS_MIN_LO, 32'h0000_0002);
    wr(OFS_MIN_HI, 32'h0000_0001);
    wr(OFS_MAX_LO, 32'h0000_0005);
    wr(OFS_MAX_HI, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0006);
    ld(LB + 4);
    cnt_is(LB + 4);
    cnt_is(LB + 2);
    wr(OFS_CONTROL, 32'h0000_0004);
    ld(LB + 4);
    pulses(2);
    cnt_is(LB + 2);
    wr(OFS_CONTROL, 32'h0000_0014);
    ld(LB + 3);
    pulses(2);
    cnt_is(LB + 5);
    wr(OFS_CONTROL, 32'h0000_000C);
    ld(LB + 4);
    pulses(3);
    cnt_is(LB + 5);
    rd(OFS_STATUS);
    check(rdat, 32'h0000_0006);
    wr(OFS_CONTROL, 32'h0000_001C);
    pulses(1);
    cnt_is(LB + 4);
    pulses(4);
    cnt_is(LB + 2);
    ld(LB + 4);
    pulses(1);
    cnt_is(LB + 3);
    $display("test limits done");
  endtask : t_limits
  task automatic t_gate;
    wr(OFS_CONTROL, 32'h0000_0200);
    ld(64'hA);
    pulses(3);
    cnt_is(64'hA);
    gate_to(1'b1);
    pulses(2);
    cnt_is(64'hC);
    wr(OFS_CONTROL, 32'h0000_0300);
    gate_to(1'b0);
    gate_to(1'b1);
    cnt_is(64'h0);
    wr(OFS_CONTROL, 32'h0000_0304);
    ld(64'h9);
    gate_to(1'b0);
    gate_to(1'b1);
    cnt_is(LB + 2);
    gate_to(1'b0);
    wr(OFS_CONTROL, 32'h0000_0400);
    ld(64'h0);
    pulses(3);
    cnt_is(64'h0);
    gate_to(1'b1);
    pulses(2);
    cnt_is(64'h2);
    $display("test gate done");
  endtask : t_gate
  task automatic t_output;
    wr(OFS_CMP0_LO, 32'h0000_0002);
    wr(OFS_CMP1_LO, 32'h0000_0004);
    ld(64'h0);
    wr(OFS_CONTROL, 32'h0000_0020);
    check(cout, 1'b0);
    pulses(2);
    check(cout, 1'b1);
    pulses(2);
    check(cout, 1'b0);
    wr(OFS_CONTROL, 32'h0000_0060);
    repeat (4) @(posedge CLOCK);
    check(cout, 1'b1);
    $display("test output done");
  endtask : t_output
  task automatic t_period;
    int tk[7] = '{0, 0, 0, 0, 1, 2, 3};
    int av[7] = '{0, 1, 2, 3, 0, 0, 0};
    int hf[7] = '{10, 10, 10, 6, 260, 1400, 2700};
    int np[4] = '{1, 10, 100, 1000};
    int tp[4] = '{TICK0_PS, TICK1_PS, TICK2_PS, TICK3_PS};
    longint e;
    logic [63:0] pv;
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CONTROL, 32'(tk[i] * 16384 + av[i] * 4096 + (i % 2) * 2048 + 1));
      @(posedge CLOCK);
      half <= 16'(hf[i]);
      cnt <= 16'h0000;
      go <= 1'b1;
      repeat ((2 * np[av[i]] + 2) * 2 * hf[i]) @(posedge CLOCK);
      go <= 1'b0;
      wait (!busy);
      repeat (8) @(posedge CLOCK);
      rd(OFS_PERIOD_LO);
      pv[31:0] = rdat;
      rd(OFS_PERIOD_HI);
      pv[63:32] = rdat;
      e = longint'(hf[i]) * 8000 * np[av[i]] / tp[tk[i]];
      check(pv, ((pv + 1 >= e && pv <= e + 1) === 1'b1) ? pv : 64'(e));
      repeat (100) @(posedge CLOCK);
      rd(OFS_PERIOD_LO);
      check(rdat, pv[31:0]);
    end
    wr(OFS_CONTROL, 32'h0001_0001);
    pulses(3);
    rd(OFS_PERIOD_LO);
    check(rdat != 32'h0000_0000, 1'b1);
    gate_to(1'b0);
    pulses(3);
    rd(OFS_PERIOD_LO);
    check(rdat, 32'h0000_0000);
    $display("test period done");
  endtask : t_period
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    t_reset();
    t_direction();
    t_limits();
    t_gate();
    t_output();
    t_period();
    conclude();
  end
  initial begin
    repeat (90000) @(posedge CLOCK);
    miscompares++;
    conclude();
  end
endmodule : test_totalize_period_counter
`default_nettype wire
